// ### include/mpc_pkg.sv
package mpc_pkg;
  localparam int            NUM_REGS     = 3;
  localparam logic [11:0]   REG_IDX [3]  = '{12'h0a4, 12'h0a6, 12'h0a8};
  localparam logic [11:0]   STATUS_IDX   = 12'h0aa;
  localparam int            PER_REG      = 0;
  localparam int            MID_REG      = 1;
  localparam int            AUX_REG      = 2;
  localparam logic [15:0]   REG_WMASK [3] = '{16'hff8f, 16'hfe07, 16'h7fc7};
  localparam logic [15:0]   REG_ONES  [3] = '{16'h0070, 16'h01f8, 16'h8038};
  localparam int            PER_BASE_LSB = 7;
  localparam int            MID_BASE_LSB = 9;
  localparam int            AUX_SIZE_LSB = 8;
  localparam int            AUX_PIN_BIT  = 7;
  localparam int            AUX_SPACE_BIT = 6;
  localparam int            WAIT_HI_BIT  = 3;
  localparam int            RDY_BIT      = 2;
  localparam logic [2:0]    UP_WIN_LO    = 3'h5;
  localparam logic [2:0]    UP_WIN_HI    = 3'h6;
  localparam logic [1:0]    RESP_OKAY    = 2'h0;
  localparam logic [1:0]    RESP_SLVERR  = 2'h2;
  localparam logic [3:0]    PER_WAITS [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h9, 4'hf};

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_READY = 2'b10
  } mpc_state_e;
endpackage

// ### logic/mpc_select.sv
`timescale 1ns/100ps
`default_nettype none
module mpc_select
  import mpc_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic [11:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [11:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        cycle_start_i,
  input  wire logic [19:0] addr_i,
  input  wire logic        mem_cycle_i,
  input  wire logic        ext_ready_i,
  output logic             cycle_done_o,
  output logic [3:0]       midrange_select_n_o,
  output logic [1:0]       upper_peripheral_selects_n_o,
  output logic [3:0]       lower_peripheral_selects_n_o
);

  logic [15:0] reg_ff [NUM_REGS];
  logic [2:0]  written_ff;
  logic        aux_touch_ff;
  logic        awready_ff;
  logic        wready_ff;
  logic        aw_hold_ff;
  logic        w_hold_ff;
  logic [11:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        arready_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        rdy_meta_ff;
  logic        rdy_sync_ff;
  mpc_state_e  state_ff;
  logic [3:0]  wait_cnt_ff;
  logic        need_rdy_ff;
  logic        done_ff;
  logic [3:0]  mid_n_ff;
  logic [1:0]  up_n_ff;
  logic [3:0]  lo_n_ff;

  logic        do_wr;
  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic [2:0]  wr_hit;
  logic        rd_known;
  logic [15:0] rd_word;
  logic [15:0] status_word;
  logic [8:0]  per_base;
  logic [6:0]  mid_base;
  logic [6:0]  size_field;
  logic [6:0]  size_mask;
  logic        size_onehot;
  logic        pin_sel;
  logic        mid_active;
  logic        per_active;
  logic        addr_mode;
  logic        mid_hit;
  logic        per_base_hit;
  logic        lo_hit;
  logic        up_hit;
  logic [2:0]  win;
  logic [1:0]  sub_idx;
  logic        start_hit;
  logic        finish;
  logic [3:0]  nxt_wait;
  logic        nxt_need_rdy;

  assign aw_take = awready_ff && s_axi_awvalid_i;
  assign w_take  = wready_ff && s_axi_wvalid_i;
  assign ar_take = arready_ff && s_axi_arvalid_i;
  assign do_wr   = aw_hold_ff && w_hold_ff && !bvalid_ff;

  // Address and data are taken independently; the response waits for both
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      awready_ff <= 1'b0;
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= 12'h000;
    end else if (aw_take) begin
      awready_ff <= 1'b0;
      aw_hold_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr_i;
    end else begin
      if (do_wr) aw_hold_ff <= 1'b0;
      if (!aw_hold_ff && !bvalid_ff) awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wready_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else if (w_take) begin
      wready_ff <= 1'b0;
      w_hold_ff <= 1'b1;
      w_data_ff <= s_axi_wdata_i;
      w_strb_ff <= s_axi_wstrb_i;
    end else begin
      if (do_wr) w_hold_ff <= 1'b0;
      if (!w_hold_ff && !bvalid_ff) wready_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (wr_hit != 3'b000) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Fixed bits are forced on every write, so reads show them as set
  for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
    assign wr_hit[i] = do_wr && (aw_addr_ff[11:2] == REG_IDX[i][9:0]);
    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        reg_ff[i]     <= REG_ONES[i];
        written_ff[i] <= 1'b0;
      end else if (wr_hit[i]) begin
        reg_ff[i][15:8] <= ((w_strb_ff[1] ? w_data_ff[15:8] : reg_ff[i][15:8])
                            & REG_WMASK[i][15:8]) | REG_ONES[i][15:8];
        reg_ff[i][7:0]  <= ((w_strb_ff[0] ? w_data_ff[7:0] : reg_ff[i][7:0])
                            & REG_WMASK[i][7:0]) | REG_ONES[i][7:0];
        written_ff[i]   <= 1'b1;
      end
    end
  end

  assign status_word = {12'h000, state_ff == ST_READY, state_ff != ST_IDLE,
                        per_active, mid_active};

  always_comb begin
    rd_known = 1'b0;
    rd_word  = 16'h0000;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (s_axi_araddr_i[11:2] == REG_IDX[i][9:0]) begin
        rd_known = 1'b1;
        rd_word  = reg_ff[i];
      end
    end
    if (s_axi_araddr_i[11:2] == STATUS_IDX[9:0]) begin
      rd_known = 1'b1;
      rd_word  = status_word;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= RESP_OKAY;
    end else if (ar_take) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= {16'h0000, rd_word};
      rresp_ff   <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff) begin
      if (s_axi_rready_i) rvalid_ff <= 1'b0;
    end else begin
      arready_ff <= 1'b1;
    end
  end

  // A read of the aux register counts as an access too
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      aux_touch_ff <= 1'b0;
    end else if (wr_hit[AUX_REG] ||
                 (ar_take && s_axi_araddr_i[11:2] == REG_IDX[AUX_REG][9:0])) begin
      aux_touch_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdy_meta_ff <= 1'b0;
      rdy_sync_ff <= 1'b0;
    end else begin
      rdy_meta_ff <= ext_ready_i;
      rdy_sync_ff <= rdy_meta_ff;
    end
  end

  assign per_base    = reg_ff[PER_REG][15:PER_BASE_LSB];
  assign mid_base    = reg_ff[MID_REG][15:MID_BASE_LSB];
  assign size_field  = reg_ff[AUX_REG][14:AUX_SIZE_LSB];
  assign pin_sel     = reg_ff[AUX_REG][AUX_PIN_BIT];
  assign mid_active  = written_ff[MID_REG] && written_ff[AUX_REG];
  assign per_active  = written_ff[PER_REG] && written_ff[AUX_REG];
  assign addr_mode   = !pin_sel && aux_touch_ff;
  assign size_onehot = (size_field != 7'h00) &&
                       ((size_field & (size_field - 7'h01)) == 7'h00);
  assign size_mask   = ~(size_field - 7'h01);

  // Only address bits above the block size take part; base bits 12..0 are zero
  assign mid_hit = mid_active && mem_cycle_i && size_onehot &&
                   (((addr_i[19:13] ^ mid_base) & size_mask) == 7'h00);

  always_comb begin
    sub_idx = 2'b00;
    for (int k = 0; k < 7; k++) begin
      if (size_field[k]) sub_idx = addr_i[11 + k +: 2];
    end
  end

  assign win          = addr_i[10:8];
  assign per_base_hit = per_active && (mem_cycle_i == reg_ff[AUX_REG][AUX_SPACE_BIT])
                        && (addr_i[19:11] == per_base);
  assign lo_hit       = per_base_hit && !win[2];
  assign up_hit       = per_base_hit && pin_sel && (win == UP_WIN_LO || win == UP_WIN_HI);

  assign start_hit = (state_ff == ST_IDLE) && cycle_start_i && (mid_hit || lo_hit || up_hit);
  assign finish    = ((state_ff == ST_WAIT) && (wait_cnt_ff == 4'h0) && !need_rdy_ff) ||
                     ((state_ff == ST_READY) && rdy_sync_ff);

  always_comb begin
    if (mid_hit) begin
      nxt_wait     = {2'b00, reg_ff[MID_REG][1:0]};
      nxt_need_rdy = !reg_ff[MID_REG][RDY_BIT];
    end else if (lo_hit) begin
      nxt_wait     = PER_WAITS[{reg_ff[PER_REG][WAIT_HI_BIT], reg_ff[PER_REG][1:0]}];
      nxt_need_rdy = !reg_ff[PER_REG][RDY_BIT];
    end else begin
      nxt_wait     = {2'b00, reg_ff[AUX_REG][1:0]};
      nxt_need_rdy = !reg_ff[AUX_REG][RDY_BIT];
    end
  end

  // Waits are counted before ready is looked at, so a fast ready cannot cut them short
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_ff    <= ST_IDLE;
      wait_cnt_ff <= 4'h0;
      need_rdy_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (start_hit) begin
            state_ff    <= ST_WAIT;
            wait_cnt_ff <= nxt_wait;
            need_rdy_ff <= nxt_need_rdy;
          end
        end
        ST_WAIT: begin
          if (wait_cnt_ff != 4'h0) wait_cnt_ff <= wait_cnt_ff - 4'h1;
          else if (need_rdy_ff) state_ff <= ST_READY;
          else state_ff <= ST_IDLE;
        end
        ST_READY: begin
          if (rdy_sync_ff) state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) done_ff <= 1'b0;
    else done_ff <= finish;
  end

  // Selects are decoded from addr_i when the cycle is offered and registered, so they show one clock later
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mid_n_ff <= 4'hf;
    end else if (start_hit) begin
      mid_n_ff <= mid_hit ? ~(4'h1 << sub_idx) : 4'hf;
    end else if (finish || state_ff == ST_IDLE) begin
      mid_n_ff <= 4'hf;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      lo_n_ff <= 4'hf;
    end else if (start_hit) begin
      lo_n_ff <= (lo_hit && !mid_hit) ? ~(4'h1 << win[1:0]) : 4'hf;
    end else if (finish || state_ff == ST_IDLE) begin
      lo_n_ff <= 4'hf;
    end
  end

  // In address mode the pins carry a1 on the lower and a2 on the upper pin
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      up_n_ff <= 2'b11;
    end else if (addr_mode) begin
      if (cycle_start_i) up_n_ff <= {addr_i[2], addr_i[1]};
    end else if (start_hit) begin
      up_n_ff <= (up_hit && !mid_hit) ? ((win == UP_WIN_HI) ? 2'b01 : 2'b10) : 2'b11;
    end else if (finish || state_ff == ST_IDLE) begin
      up_n_ff <= 2'b11;
    end
  end

  assign s_axi_awready_o              = awready_ff;
  assign s_axi_wready_o               = wready_ff;
  assign s_axi_bvalid_o               = bvalid_ff;
  assign s_axi_bresp_o                = bresp_ff;
  assign s_axi_arready_o              = arready_ff;
  assign s_axi_rvalid_o               = rvalid_ff;
  assign s_axi_rdata_o                = rdata_ff;
  assign s_axi_rresp_o                = rresp_ff;
  assign cycle_done_o                 = done_ff;
  assign midrange_select_n_o          = mid_n_ff;
  assign lower_peripheral_selects_n_o = lo_n_ff;
  assign upper_peripheral_selects_n_o = up_n_ff;

endmodule // mpc_select
`default_nettype wire

// ### dv/mpc_select_props.sv
`timescale 1ns/100ps
`default_nettype none
module mpc_select_props (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        cycle_start_i,
  input wire logic [19:0] addr_i,
  input wire logic        mem_cycle_i,
  input wire logic        cycle_done_o,
  input wire logic [3:0]  midrange_select_n_o,
  input wire logic [3:0]  lower_peripheral_selects_n_o,
  input wire logic [1:0]  upper_peripheral_selects_n_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i
);
  logic ms;
  logic ls;
  logic us;
  assign ms = ~&midrange_select_n_o;
  assign ls = ~&lower_peripheral_selects_n_o;
  assign us = ~&upper_peripheral_selects_n_o;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_rise;
    !(ms || ls) ##1 (ms || ls);
  endsequence
  sequence s_held;
    (ms || ls) && !cycle_done_o ##1 !cycle_done_o;
  endsequence
  AST_RST_IDLE: assert property (
    $fell(rst_i) |-> !ms && !ls && &upper_peripheral_selects_n_o && !cycle_done_o)
    else $error("selects active after reset");
  AST_START_FIRST: assert property (s_rise |-> $past(cycle_start_i))
    else $error("select without a cycle start");
  AST_MID_MEM: assert property (s_rise ##0 ms |-> $past(mem_cycle_i))
    else $error("midrange select in an io cycle");
  AST_MID_ONEHOT: assert property ($countones(~midrange_select_n_o) <= 1)
    else $error("two midrange selects at once");
  AST_LOW_WIN: assert property (
    $rose(ls) |-> lower_peripheral_selects_n_o == ~(4'h1 << $past(addr_i[9:8])))
    else $error("wrong lower window");
  AST_HOLD: assert property (s_held |-> $stable(midrange_select_n_o)
    && $stable(lower_peripheral_selects_n_o)) else $error("select moved early");
  AST_DONE_PULSE: assert property (cycle_done_o |=> !cycle_done_o)
    else $error("done longer than a cycle");
  AST_DONE_FREES: assert property (cycle_done_o |-> !ms && !ls)
    else $error("select still low at done");
  AST_DONE_CAUSE: assert property (
    $rose(cycle_done_o) |-> $past(ms) || $past(ls) || $past(us))
    else $error("done without a select");
  AST_B_STAND: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("bvalid dropped");
  AST_R_STAND: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o)
    else $error("rvalid dropped");
endmodule // mpc_select_props
bind mpc_select mpc_select_props u_props (.clock_i, .rst_i, .cycle_start_i, .addr_i,
  .mem_cycle_i, .cycle_done_o, .midrange_select_n_o, .lower_peripheral_selects_n_o,
  .upper_peripheral_selects_n_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_rvalid_o,
  .s_axi_rready_i);
`default_nettype wire

// ### dv/mpc_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
module mpc_bus_model (
  input wire logic       clock_i,
  input wire logic [9:0] sel_n_i,
  input wire logic [5:0] delay_i,
  output logic           ext_ready_o
);
  logic [5:0] cnt_ff;
  always_ff @(posedge clock_i) begin
    if (&sel_n_i) cnt_ff <= 6'h00;
    else if (cnt_ff != 6'h3f) cnt_ff <= cnt_ff + 6'h01;
  end
  // A slow device: ready only after delay_i cycles of select, low when idle
  assign ext_ready_o = !(&sel_n_i) && (cnt_ff >= delay_i);
endmodule // mpc_bus_model
`default_nettype wire

// ### dv/midrange_peripheral_chip_select_test.sv
`timescale 1ns/100ps
`default_nettype none
module midrange_peripheral_chip_select_test import mpc_pkg::*; ();
  localparam logic [11:0] PA = 12'h290;
  localparam logic [11:0] MA = 12'h298;
  localparam logic [11:0] XA = 12'h2a0;
  localparam logic [9:0]  NO = 10'h3ff;
  localparam int          WT [8] = '{0, 1, 2, 3, 5, 7, 9, 15};
  logic clock_i, rst_i, aw_v, w_v, b_r, ar_v, r_r, start, mem, rdy;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, done;
  logic [11:0] aw_a, ar_a;
  logic [31:0] w_d, r_d;
  logic [3:0]  w_s, mid_n, lo_n;
  logic [1:0]  b_resp, r_resp, up_n;
  logic [19:0] addr;
  logic [5:0]  dly;
  int          n_errors, cmp_count, cyc;
  mpc_select u_dut (.clock_i(clock_i), .rst_i(rst_i), .s_axi_awaddr_i(aw_a),
    .s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_rdy), .s_axi_wdata_i(w_d),
    .s_axi_wstrb_i(w_s), .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_rdy),
    .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r),
    .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v), .s_axi_arready_o(ar_rdy),
    .s_axi_rdata_o(r_d), .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_v),
    .s_axi_rready_i(r_r), .cycle_start_i(start), .addr_i(addr), .mem_cycle_i(mem),
    .ext_ready_i(rdy), .cycle_done_o(done), .midrange_select_n_o(mid_n),
    .upper_peripheral_selects_n_o(up_n), .lower_peripheral_selects_n_o(lo_n));
  // The model watches every select output, including the upper pins that carry a1 and a2 in address mode
  mpc_bus_model u_model (.clock_i(clock_i), .sel_n_i({mid_n, lo_n, up_n}), .delay_i(dly),
    .ext_ready_o(rdy));
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  task tally_and_finish;
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      tally_and_finish;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clock_i);
    {aw_a, w_d} <= {a, 16'h0000, d};
    {aw_v, w_v, b_r} <= 3'b111;
    while (pa || pw) begin
      @(negedge clock_i);
      if (aw_rdy === 1'b1) pa = 1'b0;
      if (w_rdy === 1'b1) pw = 1'b0;
      @(posedge clock_i);
      {aw_v, w_v} <= {pa, pw};
    end
    do @(negedge clock_i); while (b_v !== 1'b1);
    chk(32'(b_resp), 32'(er));
    @(posedge clock_i);
    b_r <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clock_i);
    {ar_a, ar_v, r_r} <= {a, 2'b11};
    do @(negedge clock_i); while (ar_rdy !== 1'b1);
    @(posedge clock_i);
    ar_v <= 1'b0;
    do @(negedge clock_i); while (r_v !== 1'b1);
    chk(r_d, ed);
    chk(32'(r_resp), 32'(er));
    @(posedge clock_i);
    r_r <= 1'b0;
  endtask
  // lo/hi bound the cycles from select to done; 40 means no done is expected at all
  task bcyc(input logic [19:0] a, input logic m, input logic [9:0] es, input int lo,
            input int hi);
    int n;
    @(posedge clock_i);
    {addr, mem, start} <= {a, m, 1'b1};
    @(posedge clock_i);
    start <= 1'b0;
    @(negedge clock_i);
    chk(32'({mid_n, lo_n, up_n}), 32'(es));
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(negedge clock_i);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask
  task t_reset;
    @(negedge clock_i);
    chk(32'({mid_n, lo_n, up_n}), 32'(NO));
    rd(12'h2a8, 32'h0, RESP_OKAY);
    wr(12'h2a8, 16'h0003, RESP_SLVERR);
    rd(PA, 32'h0070, RESP_OKAY);
    rd(MA, 32'h01f8, RESP_OKAY);
    rd(12'h2b0, 32'h0, RESP_SLVERR);
    wr(12'h2b0, 16'h1234, RESP_SLVERR);
  endtask
  task t_gate;
    bcyc(20'h20000, 1'b1, NO, 40, 40);
    wr(MA, 16'h21fe, RESP_OKAY);
    bcyc(20'h20000, 1'b1, NO, 40, 40);
    wr(PA, 16'h0874, RESP_OKAY);
    bcyc(20'h08000, 1'b1, NO, 40, 40);
    wr(XA, 16'h84fd, RESP_OKAY);
    rd(XA, 32'h84fd, RESP_OKAY);
    rd(12'h2a8, 32'h3, RESP_OKAY);
  endtask
  task t_mid;
    for (int i = 0; i < 4; i++)
      bcyc(20'h20123 | (20'(i) << 13), 1'b1, {~(4'h1 << i), 6'h3f}, 3, 3);
    bcyc(20'h28000, 1'b1, NO, 40, 40);
    bcyc(20'h20000, 1'b0, NO, 40, 40);
  endtask
  task t_waits;
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      wr(PA, {12'h087, c[2], 1'b1, c[1:0]}, RESP_OKAY);
      bcyc(20'h08000 | (20'(c[1:0]) << 8), 1'b1, {4'hf, ~(4'h1 << c[1:0]), 2'h3},
           WT[i] + 1, WT[i] + 1);
    end
  endtask
  task t_upper;
    bcyc(20'h08500, 1'b1, {8'hff, 2'b10}, 2, 2);
    bcyc(20'h08600, 1'b1, {8'hff, 2'b01}, 2, 2);
    bcyc(20'h08400, 1'b1, NO, 40, 40);
  endtask
  task t_space;
    wr(PA, 16'h0874, RESP_OKAY);
    bcyc(20'h08000, 1'b0, NO, 40, 40);
    wr(XA, 16'h84bd, RESP_OKAY);
    bcyc(20'h08100, 1'b0, {4'hf, 4'hd, 2'h3}, 1, 1);
    bcyc(20'h08100, 1'b1, NO, 40, 40);
  endtask
  task t_ready;
    dly <= 6'd6;
    wr(PA, 16'h0871, RESP_OKAY);
    bcyc(20'h08200, 1'b0, {4'hf, 4'hb, 2'h3}, 7, 12);
    wr(MA, 16'h21fa, RESP_OKAY);
    bcyc(20'h20000, 1'b1, {4'he, 4'hf, 2'h3}, 7, 12);
    wr(XA, 16'h84b9, RESP_OKAY);
    bcyc(20'h08500, 1'b0, {8'hff, 2'b10}, 7, 12);
  endtask
  task t_addr_mode;
    wr(XA, 16'h843d, RESP_OKAY);
    bcyc(20'h30004, 1'b1, {8'hff, 2'b10}, 40, 40);
    bcyc(20'h30002, 1'b1, {8'hff, 2'b01}, 40, 40);
  endtask
  initial begin
    {aw_v, w_v, b_r, ar_v, r_r, start, mem} = 7'h00;
    {aw_a, ar_a, w_d, addr} = '0;
    w_s = 4'h3;
    dly = 6'd30;
    rst_i = 1'b1;
    {n_errors, cmp_count, cyc} = '0;
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset;
    t_gate;
    t_mid;
    t_waits;
    t_upper;
    t_space;
    t_ready;
    t_addr_mode;
    tally_and_finish;
  end
endmodule // midrange_peripheral_chip_select_test
`default_nettype wire
